// file: verilog/ifca_bridge.sv
// apb slave that bridges host accesses to the fabric register space
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "ifca_defines.svh"
// Function
// - data register carries the word written to or read from the fabric
// - each transfer targets the register named by the 16-bit index
// - in read direction, data register reads return fetched fabric value
// - in write direction, data register reads return last host write made while not pending
// - writing one to bit 31 launches one transfer with current index
// - pending flag holds during a transfer, self-clears, resets to zero
// - for reads, pending clears only once fabric data is captured
// - bit 30 chooses direction, zero write, one read, reset zero
// - with increment on, a data register write starts a write transfer
// - with increment on, index steps up after each auto write completes
// - with increment on, data register read steps index and starts fetch
// - increment wins when both increment and decrement are set
// - bit 28 enables decrement, mirroring increment with index down
// - bits 19:16 are a byte-lane mask for writes to the fabric
// - the index sits in bits 15:0, read-write, reset zero
module ifca_bridge
   import ifca_pkg::*;
(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output      logic [31:0]           prdata,
   output      logic                  pready,
   output      logic                  pslverr,
   output      logic                  fab_req,
   output      logic                  fab_write,
   output      ifca_pkg::ifca_index_t fab_index,
   output      logic [31:0]           fab_wdata,
   output      ifca_pkg::ifca_lane_t  fab_lane_mask,
   input  wire logic                  fab_ack,
   input  wire logic [31:0]           fab_rdata
);
   import ifca_pkg::*;

   // host-visible register state
   logic [31:0]  wr_word_ff;
   logic [31:0]  rd_word_ff;
   logic         pend_ff;
   logic         dir_ff;
   logic         inc_ff;
   logic         dec_ff;
   ifca_lane_t   mask_ff;
   ifca_index_t  idx_ff;
   // transfer tracking
   logic         auto_wr_ff;
   logic         auto_rd_ff;
   ifca_state_e  state_ff;
   // apb answer flops
   logic         prdy_ff;
   logic         perr_ff;
   logic [31:0]  prdata_ff;
   // fabric request flops
   logic         req_ff;
   logic         fwr_ff;
   ifca_index_t  fidx_ff;
   logic [31:0]  fwd_ff;
   ifca_lane_t   fmask_ff;
   ifca_index_t  nxt_idx;

   // decoded strobes
   logic setup;
   logic acc;
   logic hit_data;
   logic hit_cmd;
   logic data_wr;
   logic data_rd;
   logic cmd_wr;
   logic auto_on;
   logic start_cmd;
   logic start_auto_wr;
   logic start_auto_rd;
   logic start;
   logic done;

   // address decode, shared by the handshake, read mux and write strobes
   function automatic logic ifca_is_data(input logic [11:0] addr);
      return addr == `IFCA_DATA_OFFSET;
   endfunction

   function automatic logic ifca_is_cmd(input logic [11:0] addr);
      return addr == `IFCA_CMD_OFFSET;
   endfunction

   // command read-back image; reserved bits 27:20 always read as zero
   function automatic logic [31:0] ifca_cmd_image
   (
      input logic                  pend,
      input logic                  dir,
      input logic                  inc,
      input logic                  dec,
      input ifca_pkg::ifca_lane_t  mask,
      input ifca_pkg::ifca_index_t idx
   );
      return {pend, dir, inc, dec, 8'h00, mask, idx};
   endfunction

   // the apb answer is given one cycle after the setup phase
   assign setup    = psel && !penable;
   assign acc      = psel && penable && prdy_ff;
   assign hit_data = ifca_is_data(paddr);
   assign hit_cmd  = ifca_is_cmd(paddr);
   assign data_wr  = acc && pwrite && hit_data;
   assign data_rd  = acc && !pwrite && hit_data;
   assign cmd_wr   = acc && pwrite && hit_cmd;
   assign auto_on  = inc_ff || dec_ff;

   // start sources; all are blocked while a transfer is pending
   assign start_cmd     = cmd_wr && pwdata[`IFCA_PEND_BIT] && !pend_ff;
   assign start_auto_wr = data_wr && auto_on && !pend_ff;
   assign start_auto_rd = data_rd && auto_on && !pend_ff;
   assign start         = start_cmd || start_auto_wr || start_auto_rd;
   assign done          = (state_ff == IFCA_WAIT) && fab_ack;

   // index stepper shared by auto write completion and auto read
   ifca_step u_step
   (
      .index_in  (idx_ff),
      .inc_en    (inc_ff),
      .dec_en    (dec_ff),
      .index_out (nxt_idx)
   );

   // apb handshake flops; registered pready is high in the first access cycle, so there is no wait state
   // pslverr is raised only for addresses outside the two registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdy_ff <= 1'b0;
         perr_ff <= 1'b0;
      end
      else
      begin
         prdy_ff <= setup;
         perr_ff <= setup && !(hit_data || hit_cmd);
      end
   end

   // read data mux, captured during setup for a registered prdata
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_ff <= 32'h00000000;
      else if (setup && !pwrite)
      begin
         if (hit_data)
            // direction picks fetched word or last host write
            prdata_ff <= dir_ff ? rd_word_ff : wr_word_ff;
         else if (hit_cmd)
            prdata_ff <= ifca_cmd_image(pend_ff, dir_ff, inc_ff, dec_ff,
                                        mask_ff, idx_ff);
         else
            prdata_ff <= 32'h00000000;
      end
   end

   // host-written data word
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wr_word_ff <= `IFCA_DATA_RESET;
      else if (data_wr && !pend_ff)
         wr_word_ff <= pwdata;
   end

   // word fetched from the fabric; host writes never touch it, so a
   // fetched value is readable again once the direction bit is set back to read
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rd_word_ff <= `IFCA_DATA_RESET;
      else if (done && !fwr_ff)
         rd_word_ff <= fab_rdata;
   end

   // command fields; writes while pending are dropped to protect the transfer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dir_ff  <= `IFCA_DIR_WRITE;
         inc_ff  <= 1'b0;
         dec_ff  <= 1'b0;
         mask_ff <= 4'h0;
      end
      else if (cmd_wr && !pend_ff)
      begin
         dir_ff  <= pwdata[`IFCA_DIR_BIT];
         inc_ff  <= pwdata[`IFCA_INC_BIT];
         dec_ff  <= pwdata[`IFCA_DEC_BIT];
         mask_ff <= pwdata[`IFCA_MASK_HI:`IFCA_MASK_LO];
      end
   end

   // index: host write, step after auto write, step before auto read
   // a command write made while not pending reloads the index, even with a step mode on
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         idx_ff <= 16'h0000;
      else if (cmd_wr && !pend_ff)
         idx_ff <= pwdata[`IFCA_IDX_HI:`IFCA_IDX_LO];
      else if (start_auto_rd)
         idx_ff <= nxt_idx;
      else if (done && auto_wr_ff)
         idx_ff <= nxt_idx;
   end

   // pending flag; start and completion cannot coincide since start needs idle
   always_ff @(posedge pclk or negedge presetn)
   begin
      // the auto flags record which kind of start raised pending
      if (!presetn)
      begin
         pend_ff    <= 1'b0;
         auto_wr_ff <= 1'b0;
         auto_rd_ff <= 1'b0;
      end
      else if (start)
      begin
         pend_ff    <= 1'b1;
         auto_wr_ff <= start_auto_wr;
         auto_rd_ff <= start_auto_rd;
      end
      else if (done)
      begin
         pend_ff    <= 1'b0;
         auto_wr_ff <= 1'b0;
         auto_rd_ff <= 1'b0;
      end
   end

   // transfer sequencer toward the fabric
   // the issue cycle lets the index step of an auto read settle first
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_ff <= IFCA_IDLE;
      else
      begin
         unique case (state_ff)
            IFCA_IDLE:
               if (start)
                  state_ff <= IFCA_ISSUE;
            IFCA_ISSUE:
               state_ff <= IFCA_WAIT;
            IFCA_WAIT:
               if (fab_ack)
                  state_ff <= IFCA_IDLE;
            default:
               state_ff <= IFCA_IDLE;
         endcase
      end
   end

   // fabric request; fields latched at issue so they stay stable until ack
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         req_ff   <= 1'b0;
         fwr_ff   <= 1'b0;
         fidx_ff  <= 16'h0000;
         fwd_ff   <= 32'h00000000;
         fmask_ff <= 4'h0;
      end
      else if (state_ff == IFCA_ISSUE)
      begin
         req_ff   <= 1'b1;
         // auto writes always write and auto reads always fetch,
         // whatever the direction bit says
         fwr_ff   <= auto_wr_ff ||
                     (!auto_rd_ff && dir_ff == `IFCA_DIR_WRITE);
         fidx_ff  <= idx_ff;
         fwd_ff   <= wr_word_ff;
         fmask_ff <= mask_ff;
      end
      else if (done)
         req_ff <= 1'b0;
   end

   // every output is a flop; no logic sits between flop and pin
   assign prdata        = prdata_ff;
   assign pready        = prdy_ff;
   assign pslverr       = perr_ff;
   assign fab_req       = req_ff;
   assign fab_write     = fwr_ff;
   assign fab_index     = fidx_ff;
   assign fab_wdata     = fwd_ff;
   assign fab_lane_mask = fmask_ff;
endmodule // ifca_bridge

// file: verilog/ifca_defines.svh
// constants for the indirect fabric register bridge
`ifndef IFCA_DEFINES_SVH
`define IFCA_DEFINES_SVH
`define IFCA_DATA_OFFSET   12'h1ac
`define IFCA_CMD_OFFSET    12'h1b0
`define IFCA_DATA_RESET    32'h00000000
`define IFCA_PEND_BIT      31
`define IFCA_DIR_BIT       30
`define IFCA_INC_BIT       29
`define IFCA_DEC_BIT       28
`define IFCA_MASK_HI       19
`define IFCA_MASK_LO       16
`define IFCA_IDX_HI        15
`define IFCA_IDX_LO        0
`define IFCA_DIR_WRITE     1'b0
`define IFCA_DIR_READ      1'b1
`endif

// file: verilog/ifca_pkg.sv
// types for the indirect fabric register bridge
package ifca_pkg;
   typedef logic [15:0] ifca_index_t;
   typedef logic [3:0]  ifca_lane_t;
   typedef enum logic [2:0]
   {
      IFCA_IDLE  = 3'b001,
      IFCA_ISSUE = 3'b010,
      IFCA_WAIT  = 3'b100
   } ifca_state_e;
endpackage

// file: verilog/ifca_step.sv
// index stepper used for auto increment and auto decrement
`timescale 1ns/1ps
module ifca_step
   import ifca_pkg::*;
(
   input  wire ifca_pkg::ifca_index_t index_in,
   input  wire logic                  inc_en,
   input  wire logic                  dec_en,
   output      ifca_pkg::ifca_index_t index_out
);
   import ifca_pkg::*;

   // increment wins when both are set
   always_comb
   begin
      if (inc_en)
         index_out = index_in + 16'h0001;
      else if (dec_en)
         index_out = index_in - 16'h0001;
      else
         index_out = index_in;
   end
endmodule // ifca_step

// file: tb/ifca_bridge_chk.sv
// port checker for the indirect fabric bridge
`timescale 1ns/1ps
module ifca_bridge_chk
   import ifca_pkg::*;
(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   input  wire logic [31:0]           prdata,
   input  wire logic                  pready,
   input  wire logic                  pslverr,
   input  wire logic                  fab_req,
   input  wire logic                  fab_write,
   input  wire ifca_pkg::ifca_index_t fab_index,
   input  wire logic [31:0]           fab_wdata,
   input  wire ifca_pkg::ifca_lane_t  fab_lane_mask,
   input  wire logic                  fab_ack,
   input  wire logic [31:0]           fab_rdata
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [31:0] last_ff;
   wire  logic  acc = psel && penable && pready && pwrite;
   // last data word taken; writes made while a request is out are dropped
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         last_ff <= 32'h0;
      else if (acc && paddr == 12'h1ac && !fab_req)
         last_ff <= pwdata;
   chk_ready_setup: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   chk_ready_access: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   chk_err_unmapped: assert property (psel && !penable && paddr != 12'h1ac
      && paddr != 12'h1b0 |=> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   chk_err_mapped: assert property (psel && !penable && (paddr == 12'h1ac
      || paddr == 12'h1b0) |=> !pslverr)
      else $error("mapped access refused");
   chk_req_hold: assert property (fab_req && !fab_ack |=> fab_req &&
      $stable(fab_index) && $stable(fab_wdata) && $stable(fab_write))
      else $error("fabric request changed before ack");
   chk_req_drop: assert property (fab_req && fab_ack |=> !fab_req[*2])
      else $error("request not dropped after ack");
   chk_start_issue: assert property (acc && paddr == 12'h1b0 && pwdata[31]
      && !fab_req |-> ##3 fab_req && fab_index == $past(pwdata[15:0], 3)
      && fab_write == !$past(pwdata[30], 3))
      else $error("command start not issued");
   chk_write_word: assert property ($rose(fab_req) && fab_write |->
      fab_wdata == last_ff)
      else $error("write word differs from data register");
endmodule // ifca_bridge_chk
bind ifca_bridge ifca_bridge_chk chk_i (.*);

// file: tb/ifca_fabric_model.sv
// behavioural fabric register space with a settable answer delay
`timescale 1ns/1ps
module ifca_fabric_model
   import ifca_pkg::*;
(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  fab_req,
   input  wire logic                  fab_write,
   input  wire ifca_pkg::ifca_index_t fab_index,
   input  wire logic [31:0]           fab_wdata,
   input  wire ifca_pkg::ifca_lane_t  fab_lane_mask,
   input  wire logic [3:0]            lat,
   output      logic                  fab_ack,
   output      logic [31:0]           fab_rdata
);
   logic [31:0] mem_ff [16];
   logic [3:0]  cnt_ff;
   // answer after lat cycles; data toggles when not answering
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         cnt_ff    <= 4'h0;
         fab_ack   <= 1'b0;
         fab_rdata <= 32'h0;
         for (int i = 0; i < 16; i++)
            mem_ff[i] <= 32'h10000000 + i;
      end
      else if (fab_req && !fab_ack && cnt_ff == lat)
      begin
         fab_ack   <= 1'b1;
         cnt_ff    <= 4'h0;
         fab_rdata <= mem_ff[fab_index[3:0]];
         for (int b = 0; b < 4; b++)
            if (fab_write && fab_lane_mask[b])
               mem_ff[fab_index[3:0]][8*b+:8] <= fab_wdata[8*b+:8];
      end
      else
      begin
         fab_ack   <= 1'b0;
         cnt_ff    <= (fab_req && !fab_ack) ? cnt_ff + 4'h1 : 4'h0;
         fab_rdata <= ~fab_rdata;
      end
endmodule // ifca_fabric_model

// file: tb/ifca_bridge_tb.sv
// self-checking bench for the indirect fabric bridge
`timescale 1ns/1ps
module ifca_bridge_tb;
   import ifca_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic        fab_req, fab_write, fab_ack;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, fab_wdata, fab_rdata, rd;
   logic [3:0]  lat;
   ifca_index_t fab_index;
   ifca_lane_t  fab_lane_mask;
   int          failures, num_checks;
   ifca_bridge dut (.*);
   ifca_fabric_model fab (.*);
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   task automatic chk(input string n, input logic [31:0] x, y);
      num_checks++;
      if (y !== x)
      begin
         failures++;
         $display("CHECK FAILED %s exp %h got %h", n, x, y);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1 && ++n < 20);
      if (pready !== 1'b1)
      begin
         failures++;
         $display("CHECK FAILED pready exp 1 got %b", pready);
      end
      rd = prdata;
      e  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic idle();
      int n;
      n = 0;
      do
         apb(0, 12'h1b0, 0);
      while (rd[31] === 1'b1 && ++n < 30);
      chk("pending", 0, rd[31]);
   endtask
   task automatic t_reset();
      apb(0, 12'h1b0, 0);
      chk("cmd reset", 0, rd);
      apb(0, 12'h1ac, 0);
      chk("data reset", 0, rd);
      apb(0, 12'h000, 0);
      chk("unmapped", 1, e);
      $display("t_reset done");
   endtask
   task automatic t_write();
      apb(1, 12'h1ac, 32'h11223344);
      apb(1, 12'h1b0, 32'h80050003);
      apb(0, 12'h1b0, 0);
      chk("pending set", 1, rd[31]);
      apb(1, 12'h1ac, 32'hdeadbeef);
      idle();
      apb(0, 12'h1ac, 0);
      chk("write echo", 32'h11223344, rd);
      apb(1, 12'h1b0, 32'hc0000003);
      idle();
      apb(0, 12'h1ac, 0);
      chk("lane merge", 32'h10220044, rd);
      $display("t_write done");
   endtask
   task automatic t_auto();
      lat <= 4'h0;
      apb(1, 12'h1b0, 32'hf00f0005);
      idle();
      apb(0, 12'h1ac, 0);
      chk("fetch", 32'h10000005, rd);
      idle();
      apb(1, 12'h1b0, 32'h400f0006);
      apb(0, 12'h1ac, 0);
      chk("prefetch", 32'h10000006, rd);
      apb(0, 12'h1b0, 0);
      chk("no prefetch", 32'h400f0006, rd);
      apb(1, 12'h1b0, 32'h300f0008);
      apb(1, 12'h1ac, 32'hcafe0001);
      idle();
      apb(0, 12'h1b0, 0);
      chk("inc index", 32'h300f0009, rd);
      apb(1, 12'h1b0, 32'h100f0008);
      apb(1, 12'h1ac, 32'h5a5a5a5a);
      idle();
      apb(0, 12'h1b0, 0);
      chk("dec index", 32'h100f0007, rd);
      apb(1, 12'h1b0, 32'hc00f0008);
      idle();
      apb(0, 12'h1ac, 0);
      chk("readback", 32'h5a5a5a5a, rd);
      $display("t_auto done");
   endtask
   task automatic end_of_test();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // watchdog: the sequence needs well under a thousand cycles
   initial
   begin
      #200us;
      failures++;
      end_of_test();
   end
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      lat = 4'h8;
      presetn = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_write();
      t_auto();
      end_of_test();
   end
endmodule // ifca_bridge_tb
